// file: inc/pdt_pkg.sv
/*
   pdt_pkg: register offsets, field positions, reset values, mode codes and divider
   constants of the prescaled down timer.
   Assumes an 8-bit register port with byte addresses.
*/
package pdt_pkg;

   // register byte addresses on the plain register port
   localparam logic [7:0] PDT_PRESCALER_VALUE_OFS  = 8'hd2;
   localparam logic [7:0] PDT_COUNTER_VALUE_OFS    = 8'hd3;
   localparam logic [7:0] PDT_STATUS_CONTROL_OFS   = 8'hd4;

   // timer_status_control_reg field positions
   localparam int PDT_ZERO_FLAG_BIT   = 7;
   localparam int PDT_ZERO_IRQ_EN_BIT = 6;
   localparam int PDT_PIN_DIR_BIT     = 5;
   localparam int PDT_PIN_DATA_BIT    = 4;
   localparam int PDT_PSC_RUN_BIT     = 3;
   localparam int PDT_PSC_SEL_MSB     = 2;
   localparam int PDT_PSC_SEL_LSB     = 0;

   // widths and reset values
   localparam int         PDT_PSC_W        = 7;
   localparam int         PDT_CNT_W        = 8;
   localparam logic [6:0] PDT_PSC_RELOAD   = 7'h7f;
   localparam logic [7:0] PDT_CNT_RELOAD   = 8'hff;
   localparam logic [7:0] PDT_CNT_ZERO     = 8'h00;
   localparam logic [7:0] PDT_CNT_ONE      = 8'h01;
   localparam logic [7:0] PDT_STATUS_RESET = 8'h00;
   localparam logic [7:0] PDT_READ_UNMAPPED = 8'h00;

   // internal clock divider feeding the prescaler
   localparam int         PDT_DIV_RATIO    = 12;
   localparam logic [3:0] PDT_DIV_LAST     = 4'(PDT_DIV_RATIO - 1);

   // operating modes, one-hot
   typedef enum logic [2:0] {
      PDT_MODE_EVENT  = 3'b001,
      PDT_MODE_GATED  = 3'b010,
      PDT_MODE_OUTPUT = 3'b100
   } pdt_mode_t;

endpackage

// file: inc/pdt_clk_if.sv
/*
   pdt_clk_if: carries the prescaler clock sources from the divider and the pin
   synchroniser to the timer core.
   Assumes all three ends share one clock.
*/
`timescale 1ns/1ps
interface pdt_clk_if;
   logic div_run;
   logic div_tick;
   logic pin_level;
   logic pin_rise;

   modport div  (input div_run, output div_tick);
   modport sync (output pin_level, output pin_rise);
   modport core (output div_run, input div_tick, input pin_level, input pin_rise);
endinterface

// file: hw/pdt_pin_sync.sv
/*
   pdt_pin_sync: brings the timer pin into the clock domain and finds its rising edges.
   Assumes the pin may change at any time relative to CLK.
*/
`timescale 1ns/1ps
module pdt_pin_sync
   import pdt_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // pin and result
   input  wire logic pin_i,
   pdt_clk_if.sync   src
);
   logic meta_ff;
   logic sync_ff;
   logic prev_ff;

   // meta_ff feeds only sync_ff
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         meta_ff <= pin_i;                        // RULE22
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign src.pin_level = sync_ff;
   assign src.pin_rise  = sync_ff & ~prev_ff;    // RULE22
endmodule // pdt_pin_sync

// file: hw/pdt_div12.sv
/*
   pdt_div12: divides the internal clock by twelve into a one-cycle tick.
   Assumes div_run low freezes the count, as in the stop state.
*/
`timescale 1ns/1ps
module pdt_div12
   import pdt_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // control and tick
   pdt_clk_if.div    ctl
);
   logic [3:0] div_ff;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_ff <= 4'h0;
      end else if (ctl.div_run) begin
         div_ff <= (div_ff == PDT_DIV_LAST) ? 4'h0 : div_ff + 4'h1;
      end
   end

   assign ctl.div_tick = ctl.div_run && (div_ff == PDT_DIV_LAST);   // RULE1
endmodule // pdt_div12

// file: hw/pdt_timer.sv
/*
   pdt_timer: 8-bit down timer behind a 7-bit prescaler with tap select, three pin
   modes, a sticky zero flag and an interrupt request, reached over a plain
   register port.
   Assumes RD and WR are one-cycle strobes, never together, synchronous to CLK;
   the pin wire is resolved outside from TIMER_PIN_OE.
*/
// Added by the designer: the strobed register port and the address map.
// How it works
// (RULE1) prescaler fed by clock/12 or pin
// (RULE2) prescaler counts down; tap gives 2^n
// (RULE3) prescaler at zero reloads 7Fh
// (RULE4) prescaler value readable by software
// (RULE5) counter decrements on each tap tick
// (RULE6) counter read/write on the fly
// (RULE7) counter at zero reloads 0FFh next
// (RULE8) run clear: counter frozen, prescaler 7Fh
// (RULE9) reset: counter 0FFh, prescaler 7Fh
// (RULE10) prescaler writable while run set
// (RULE11) decrement to zero sets flag, irq
// (RULE12) write 00h or bit7 sets flag
// (RULE13) flag sticky until software clears
// (RULE14) counter write beats decrement to zero
// (RULE15) mode from direction and data bits
// (RULE16) gated: clock/12 only while pin high
// (RULE17) event: pin rising edges clock prescaler
// (RULE18) output: flag rise latches data to pin
// (RULE19) direction set drives pin push-pull
// (RULE20) runs in wait; irq wakes device
// (RULE21) stop freezes all but event counting
// (RULE22) pin synchronised before edge or gate
`timescale 1ns/1ps
module pdt_timer
   import pdt_pkg::*;
#(
   parameter int PSC_W = PDT_PSC_W,
   parameter int CNT_W = PDT_CNT_W
)(
   // clock and reset
   input  wire logic       CLK,
   input  wire logic       RESET_N,
   // register port
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   // timer pin
   input  wire logic       TIMER_PIN_I,
   output logic            TIMER_PIN_O,
   output logic            TIMER_PIN_OE,
   // power state and interrupt
   input  wire logic       STOP_MODE,
   output logic            TIMER_IRQ
);

   // sources from the divider and the pin synchroniser
   pdt_clk_if clk_src ();

   // register state
   logic [PSC_W-1:0] psc_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic             zero_flag_ff;
   logic             zero_irq_enable_ff;
   logic             pin_direction_select_ff;
   logic             pin_data_or_submode_ff;
   logic             prescaler_run_ff;
   logic [2:0]       prescale_select_ff;
   logic             zero_flag_prev_ff;
   logic             pin_out_ff;
   logic [7:0]       rdata_ff;

   // decoded strobes
   logic wr_psc;
   logic wr_cnt;
   logic wr_ctl;

   // mode and clocking
   pdt_mode_t        mode;
   logic             frozen;
   logic             src_tick;
   logic             psc_tick;
   logic             tap_tick;
   logic [PSC_W-1:0] tap_mask;
   logic             div_tick;
   logic             pin_level;
   logic             pin_rise;

   // next values
   logic [PSC_W-1:0] nxt_psc;
   logic [CNT_W-1:0] nxt_cnt;
   logic             cnt_hits_zero;
   logic             nxt_zero_flag;
   logic [7:0]       nxt_rdata;
   logic [7:0]       status_word;

   // register decode
   assign wr_psc = WR && (ADDR == PDT_PRESCALER_VALUE_OFS);
   assign wr_cnt = WR && (ADDR == PDT_COUNTER_VALUE_OFS);
   assign wr_ctl = WR && (ADDR == PDT_STATUS_CONTROL_OFS);

   // mode select
   always_comb begin
      if (pin_direction_select_ff) begin
         mode = PDT_MODE_OUTPUT;                                          // RULE15
      end else if (pin_data_or_submode_ff) begin
         mode = PDT_MODE_GATED;                                           // RULE15
      end else begin
         mode = PDT_MODE_EVENT;                                           // RULE15
      end
   end

   // in stop only the event counter keeps going, on the pin's own edges
   assign frozen = STOP_MODE && (mode != PDT_MODE_EVENT);                 // RULE21

   // the divider also stops in the stop state; it never feeds the event mode
   assign clk_src.div_run = !STOP_MODE;                                   // RULE21

   // local names for the shared clock sources
   assign div_tick  = clk_src.div_tick;
   assign pin_level = clk_src.pin_level;
   assign pin_rise  = clk_src.pin_rise;

   // prescaler source per mode
   always_comb begin
      case (mode)
         PDT_MODE_EVENT: begin
            src_tick = pin_rise;                                          // RULE17
         end
         PDT_MODE_GATED: begin
            src_tick = div_tick && pin_level;                             // RULE16
         end
         PDT_MODE_OUTPUT: begin
            src_tick = div_tick;                                          // RULE18
         end
         default: begin
            src_tick = 1'b0;
         end
      endcase
   end

   assign psc_tick = prescaler_run_ff && !frozen && src_tick;             // RULE1

   // tap n fires when the low n prescaler bits are all zero, i.e. every 2^n ticks
   // tap 0 passes every source tick, tap 7 one in 128
   assign tap_mask = PSC_W'((1 << prescale_select_ff) - 1);
   assign tap_tick = psc_tick && ((psc_ff & tap_mask) == '0);             // RULE2

   // prescaler next value
   // a write while run is clear is dropped: the run bit pins it at 7Fh
   always_comb begin
      nxt_psc = psc_ff;
      if (!prescaler_run_ff) begin
         nxt_psc = PDT_PSC_RELOAD;                                        // RULE8
      end else if (wr_psc) begin
         nxt_psc = WDATA[PSC_W-1:0];                                      // RULE10
      end else if (psc_tick) begin
         if (psc_ff == '0) begin
            nxt_psc = PDT_PSC_RELOAD;                                     // RULE3
         end else begin
            nxt_psc = psc_ff - PSC_W'(1);                                 // RULE2
         end
      end
   end

   // a run bit written low takes effect one cycle later, through prescaler_run_ff
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         psc_ff <= PDT_PSC_RELOAD;                                        // RULE9
      end else begin
         psc_ff <= nxt_psc;
      end
   end

   // counter next value; the software write always wins
   // a write in the cycle of a decrement to zero leaves the flag alone unless it writes 00h
   always_comb begin
      nxt_cnt       = cnt_ff;
      cnt_hits_zero = 1'b0;
      if (wr_cnt) begin
         nxt_cnt = WDATA[CNT_W-1:0];                                      // RULE6 RULE14
      end else if (tap_tick) begin
         if (cnt_ff == CNT_W'(PDT_CNT_ZERO)) begin
            nxt_cnt = CNT_W'(PDT_CNT_RELOAD);                             // RULE7
         end else begin
            nxt_cnt       = cnt_ff - CNT_W'(1);                           // RULE5
            cnt_hits_zero = (cnt_ff == CNT_W'(PDT_CNT_ONE));              // RULE11
         end
      end
   end

   // tap_tick is already gated by prescaler_run, so the counter freezes with it
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cnt_ff <= PDT_CNT_RELOAD;                                        // RULE9
      end else begin
         cnt_ff <= nxt_cnt;                                               // RULE8
      end
   end

   // zero flag: any set beats a software clear in the same cycle
   // the flag is the one bit that hardware and software both write
   always_comb begin
      nxt_zero_flag = zero_flag_ff;
      if (wr_ctl) begin
         nxt_zero_flag = WDATA[PDT_ZERO_FLAG_BIT];                        // RULE13
      end
      if (cnt_hits_zero) begin
         nxt_zero_flag = 1'b1;                                            // RULE11
      end
      if (wr_cnt && (WDATA == PDT_CNT_ZERO)) begin
         nxt_zero_flag = 1'b1;                                            // RULE12
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         zero_flag_ff <= PDT_STATUS_RESET[PDT_ZERO_FLAG_BIT];
      end else begin
         zero_flag_ff <= nxt_zero_flag;                                   // RULE13
      end
   end

   // interrupt enable bit
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         zero_irq_enable_ff <= PDT_STATUS_RESET[PDT_ZERO_IRQ_EN_BIT];
      end else if (wr_ctl) begin
         zero_irq_enable_ff <= WDATA[PDT_ZERO_IRQ_EN_BIT];                // RULE11
      end
   end

   // pin direction bit
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pin_direction_select_ff <= PDT_STATUS_RESET[PDT_PIN_DIR_BIT];
      end else if (wr_ctl) begin
         pin_direction_select_ff <= WDATA[PDT_PIN_DIR_BIT];               // RULE15
      end
   end

   // pin data or input submode bit
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pin_data_or_submode_ff <= PDT_STATUS_RESET[PDT_PIN_DATA_BIT];
      end else if (wr_ctl) begin
         pin_data_or_submode_ff <= WDATA[PDT_PIN_DATA_BIT];               // RULE15
      end
   end

   // prescaler run bit
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         prescaler_run_ff <= PDT_STATUS_RESET[PDT_PSC_RUN_BIT];
      end else if (wr_ctl) begin
         prescaler_run_ff <= WDATA[PDT_PSC_RUN_BIT];                      // RULE8
      end
   end

   // prescaler tap select
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         prescale_select_ff <= PDT_STATUS_RESET[PDT_PSC_SEL_MSB:PDT_PSC_SEL_LSB];
      end else if (wr_ctl) begin
         prescale_select_ff <= WDATA[PDT_PSC_SEL_MSB:PDT_PSC_SEL_LSB];    // RULE2
      end
   end

   // previous flag, for the rising-edge latch below
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         zero_flag_prev_ff <= 1'b0;
      end else begin
         zero_flag_prev_ff <= zero_flag_ff;
      end
   end

   // output level latch: a rising zero flag, from any cause, latches the data bit
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pin_out_ff <= 1'b0;
      end else if (zero_flag_ff && !zero_flag_prev_ff) begin
         pin_out_ff <= pin_data_or_submode_ff;                            // RULE18
      end
   end

   // the pin is driven as soon as the direction bit is set, whatever the port says
   assign TIMER_PIN_OE = pin_direction_select_ff;                         // RULE19
   assign TIMER_PIN_O  = pin_out_ff;                                      // RULE18

   // level request; no dependence on wait, so it also serves as the wake source
   // the wait state needs no input of its own: the timer simply keeps running
   assign TIMER_IRQ = zero_flag_ff && zero_irq_enable_ff;                 // RULE11 RULE20

   // status/control register as software reads it
   assign status_word = {zero_flag_ff, zero_irq_enable_ff, pin_direction_select_ff,
                         pin_data_or_submode_ff, prescaler_run_ff, prescale_select_ff};

   // read data, valid the cycle after RD only
   always_comb begin
      nxt_rdata = 8'h00;
      if (RD) begin
         case (ADDR)
            PDT_PRESCALER_VALUE_OFS: begin
               nxt_rdata = {1'b0, psc_ff};                                // RULE4
            end
            PDT_COUNTER_VALUE_OFS: begin
               nxt_rdata = cnt_ff;                                        // RULE6
            end
            PDT_STATUS_CONTROL_OFS: begin
               nxt_rdata = status_word;
            end
            default: begin
               nxt_rdata = PDT_READ_UNMAPPED;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign RDATA = rdata_ff;

   // clock sources
   pdt_div12 u_div12 (
      .clk     (CLK),
      .reset_n (RESET_N),
      .ctl     (clk_src)
   );

   pdt_pin_sync u_pin_sync (
      .clk     (CLK),
      .reset_n (RESET_N),
      .pin_i   (TIMER_PIN_I),
      .src     (clk_src)
   );

endmodule // pdt_timer

// file: test/pdt_timer_asserts.sv
/*
   pdt_timer_asserts: port-level checks of the prescaled down timer.
   Assumes it is bound to pdt_timer and sees only its ports.
*/
`timescale 1ns/1ps
module pdt_timer_asserts
   import pdt_pkg::*;
#(
   parameter int PSC_W = PDT_PSC_W,
   parameter int CNT_W = PDT_CNT_W
)(
   // clock and reset
   input wire logic       CLK,
   input wire logic       RESET_N,
   // register port
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   // pin and request
   input wire logic       TIMER_PIN_OE,
   input wire logic       TIMER_IRQ
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);

   wire ctl_wr = WR && ADDR == PDT_STATUS_CONTROL_OFS;

   sequence zero_write_s;
      WR && ADDR == PDT_COUNTER_VALUE_OFS && WDATA == PDT_CNT_ZERO;
   endsequence
   sequence status_read_s;
      RD && ADDR == PDT_STATUS_CONTROL_OFS;
   endsequence
   // no status write may clear the flag between the zero write and the read
   sequence zero_write_then_read_s;
      zero_write_s ##1 !ctl_wr ##1 status_read_s;
   endsequence

   rdata_idle_a: assert property (!RD |=> RDATA == 8'h00)
      else $error("read data not idle");
   unmapped_read_a: assert property (RD && ADDR > PDT_STATUS_CONTROL_OFS |=> RDATA == 8'h00)
      else $error("unmapped read not zero");
   psc_msb_a: assert property (RD && ADDR == PDT_PRESCALER_VALUE_OFS |=> !RDATA[7])
      else $error("prescaler top bit set");
   pin_oe_a: assert property (ctl_wr |=> TIMER_PIN_OE == $past(WDATA[5]))
      else $error("pin enable not direction bit");
   oe_hold_a: assert property (!ctl_wr |=> $stable(TIMER_PIN_OE))
      else $error("pin enable moved");
   irq_soft_set_a: assert property (ctl_wr && WDATA[7] && WDATA[6] |=> TIMER_IRQ)
      else $error("request missing after flag write");
   irq_mask_a: assert property (ctl_wr && !WDATA[6] |=> !TIMER_IRQ)
      else $error("request while disabled");
   irq_sticky_a: assert property (TIMER_IRQ && !ctl_wr |=> TIMER_IRQ)
      else $error("request dropped by itself");
   zero_write_flag_a: assert property (zero_write_then_read_s |=> RDATA[7])
      else $error("zero write left flag clear");
endmodule // pdt_timer_asserts

bind pdt_timer pdt_timer_asserts #(.PSC_W(PSC_W), .CNT_W(CNT_W)) chk_u (
   .CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .TIMER_PIN_OE(TIMER_PIN_OE), .TIMER_IRQ(TIMER_IRQ));

// file: test/pdt_pin_src.sv
/*
   pdt_pin_src: pulse and level source on the timer pin.
   Assumes the bench resolves the wire from the timer's output enable.
*/
`timescale 1ns/1ps
module pdt_pin_src (
   // clock
   input wire logic clk,
   // level offered to the pin
   output logic     level
);
   initial level = 1'b0;

   // levels last several cycles so the three-flop synchroniser cannot miss one
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk);
         level <= 1'b1;
         repeat (4) @(posedge clk);
         level <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask

   task automatic hold_high(input int cyc);
      @(posedge clk);
      level <= 1'b1;
      repeat (cyc) @(posedge clk);
      level <= 1'b0;
   endtask
endmodule // pdt_pin_src

// file: test/pdt_timer_tb.sv
/*
   pdt_timer_tb: self-checking bench for the prescaled down timer.
   Assumes pdt_pin_src stands on the pin and the checker is bound.
*/
`timescale 1ns/1ps
module pdt_timer_tb;
   import pdt_pkg::*;
   logic       clk, reset_n, wr, rd, stop, pin_o, oe, irq, src_level;
   logic [7:0] addr, wdata, rdata, q;
   int         errors, samples_checked, cycles, n;
   localparam logic [7:0] A_PS = PDT_PRESCALER_VALUE_OFS;
   localparam logic [7:0] A_CN = PDT_COUNTER_VALUE_OFS;
   localparam logic [7:0] A_SC = PDT_STATUS_CONTROL_OFS;
   // the timer wins the wire whenever it drives
   wire pin_w = oe ? pin_o : src_level;

   pdt_timer dut_u (.CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .TIMER_PIN_I(pin_w), .TIMER_PIN_O(pin_o),
      .TIMER_PIN_OE(oe), .STOP_MODE(stop), .TIMER_IRQ(irq));
   pdt_pin_src src_u (.clk(clk), .level(src_level));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic wrap_up;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         errors++;
      end
   endtask

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rreg(a, d);
      chk(d, exp);
   endtask

   task automatic rst;
      if (reset_n === 1'b1) begin
         @(posedge clk);
      end
      reset_n <= 1'b0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
   endtask

   task automatic t_reset;
      rst();
      rchk(A_PS, 8'h7f);
      rchk(A_CN, 8'hff);
      rchk(A_SC, 8'h00);
      rchk(8'hd5, 8'h00);
      chk({6'h0, oe, irq}, 8'h00);
   endtask

   task automatic t_flag;
      rst();
      wreg(A_SC, 8'h40);
      wreg(A_CN, 8'h00);
      rchk(A_SC, 8'hc0);
      chk({7'h0, irq}, 8'h01);
      wreg(A_SC, 8'h40);
      rchk(A_SC, 8'h40);
      wreg(A_SC, 8'hc0);
      rchk(A_SC, 8'hc0);
      wreg(A_SC, 8'h80);
      #1 chk({7'h0, irq}, 8'h00);
      wreg(A_CN, 8'h5a);
      rchk(A_CN, 8'h5a);
   endtask

   task automatic t_output;
      rst();
      wreg(A_CN, 8'h02);
      wreg(A_SC, 8'h78);
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
         @(posedge clk);
         #1 n++;
      end
      chk({7'h0, n inside {[10:28]}}, 8'h01);
      repeat (2) @(posedge clk);
      #1 chk({6'h0, oe, pin_o}, 8'h03);
      rchk(A_SC, 8'hf8);
      rchk(A_CN, 8'h00);
      wreg(A_SC, 8'h00);
      repeat (3) @(posedge clk);
      rchk(A_PS, 8'h7f);
      rreg(A_CN, q);
      repeat (40) @(posedge clk);
      rchk(A_CN, q);
   endtask

   task automatic t_presc_write;
      rst();
      wreg(A_SC, 8'h18);
      wreg(A_PS, 8'h05);
      rchk(A_PS, 8'h05);
      wreg(A_SC, 8'h10);
      wreg(A_PS, 8'h33);
      rchk(A_PS, 8'h7f);
   endtask

   task automatic t_gated;
      rst();
      wreg(A_SC, 8'h18);
      repeat (48) @(posedge clk);
      rchk(A_CN, 8'hff);
      src_u.hold_high(120);
      repeat (8) @(posedge clk);
      rreg(A_CN, q);
      chk({7'h0, q inside {[8'hf4:8'hf6]}}, 8'h01);
   endtask

   task automatic t_event_stop;
      rst();
      stop <= 1'b1;
      wreg(A_SC, 8'h09);
      src_u.pulses(4);
      repeat (6) @(posedge clk);
      rchk(A_CN, 8'hfd);
      rchk(A_PS, 8'h7b);
      wreg(A_SC, 8'h38);
      repeat (40) @(posedge clk);
      rchk(A_CN, 8'hfd);
      @(posedge clk);
      stop <= 1'b0;
      wreg(A_SC, 8'h08);
      wreg(A_CN, 8'h01);
      wreg(A_PS, 8'h01);
      src_u.pulses(2);
      repeat (6) @(posedge clk);
      rchk(A_CN, 8'hff);
      rchk(A_PS, 8'h7f);
      rchk(A_SC, 8'h88);
   endtask

   initial begin
      reset_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      stop = 1'b0;
      t_reset();
      t_flag();
      t_output();
      t_presc_write();
      t_gated();
      t_event_stop();
      wrap_up();
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         wrap_up();
      end
   end
endmodule // pdt_timer_tb
